// ===== park_seq_defs.svh
`ifndef PARK_SEQ_DEFS_SVH
`define PARK_SEQ_DEFS_SVH

// Times in their own units; cycle counts derive from the 40 MHz clock.
`define CLK_HZ 40000000
`define RESET_HOLD_MS 5
`define RESET_HOLD_CYC ((`RESET_HOLD_MS * `CLK_HZ + 999) / 1000)
`define NORMAL_PARK_MS 20
`define NORMAL_PARK_CYC ((`NORMAL_PARK_MS * `CLK_HZ) / 1000)
`define FAST_PARK_US 32
`define FAST_PARK_CYC ((`FAST_PARK_US * `CLK_HZ) / 1000000)
`define SUPPLY_HOLD_MS 50
`define SUPPLY_HOLD_CYC ((`SUPPLY_HOLD_MS * `CLK_HZ + 999) / 1000)
`define PLL_LOCK_CYC 64
`define CFG_LOAD_CYC 256
`define NORMAL_PARK_DEV_CYC 4000
`define FAST_PARK_DEV_CYC 600

`endif

// ===== park_seq_pkg.sv
package park_seq_pkg;
  typedef enum logic [5:0] {
    ST_RESET = 6'b00_0001,
    ST_PLL = 6'b00_0010,
    ST_LOAD = 6'b00_0100,
    ST_ON = 6'b00_1000,
    ST_PARK = 6'b01_0000,
    ST_OFF = 6'b10_0000
  } dev_state_t;
  typedef enum logic [4:0] {
    HS_HOLD = 5'b0_0001,
    HS_WAIT_INIT = 5'b0_0010,
    HS_RUN = 5'b0_0100,
    HS_PARK_WAIT = 5'b0_1000,
    HS_DONE = 5'b1_0000
  } host_state_t;
endpackage : park_seq_pkg

// ===== park_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface park_link_if;
  logic projector_on_request;
  logic system_reset_n;
  logic fast_park_request_n;
  logic init_busy_out;
  logic init_busy_oe_n;
  logic i2c_allowed;
  logic main_system_supply;
  logic host_io_supply;
  logic core_supply;
  // Pull-up on the init-busy line when the device lets it go.
  wire init_busy_line = init_busy_oe_n ? 1'b1 : init_busy_out;
  modport device (
    input projector_on_request,
    input system_reset_n,
    input fast_park_request_n,
    input core_supply,
    input host_io_supply,
    output init_busy_out,
    output init_busy_oe_n
  );
  modport host (
    output projector_on_request,
    output system_reset_n,
    output fast_park_request_n,
    output i2c_allowed,
    output main_system_supply,
    output host_io_supply,
    output core_supply,
    input init_busy_line
  );
endinterface : park_link_if
`default_nettype wire

// ===== park_device.sv
// Summary of operation
// - Projector-on high powers up and projects images.
// - Projector-on low shuts down to off state.
// - Initialization starts at system reset rising edge.
// - Init-busy driven low when initialization finishes.
// - Fast-park high before reset is released.
// - Reset held 5 ms after supplies good.
// - No host I2C until init-busy low.
// - Host stops I2C before lowering projector-on.
// - Normal park completes within 20 ms.
// - Clock and supplies kept 20 ms after.
// - During reset init-busy released, pulled high.
// - Fast-park request low starts fast park.
// - Supplies kept 32 us after fast park.
// - Core power lost: host-side outputs high impedance.
// - Main supply kept 50 ms after projector-on falls in normal park.
// - Init-busy driven high during PLL and load.
// - Projector-on not lowered before init-busy low.
// - In reset light selects, mirror reset low.
`timescale 1ns/1ps
`default_nettype none
`include "park_seq_defs.svh"
module park_device #(
  parameter int PLL_LOCK_CYC = `PLL_LOCK_CYC,
  parameter int CFG_LOAD_CYC = `CFG_LOAD_CYC,
  parameter int NORMAL_PARK_CYC = `NORMAL_PARK_DEV_CYC,
  parameter int FAST_PARK_CYC = `FAST_PARK_DEV_CYC
) (
  input wire logic clk,
  park_link_if.device link,
  output logic projecting,
  output logic mirror_array_reset_n,
  output logic light_select_0,
  output logic parked,
  output logic fast_parked,
  output logic outputs_oe_n
);
  import park_seq_pkg::*;

  // Park budgets must fit the windows the power manager guarantees.
  localparam int NP_LIMIT = `NORMAL_PARK_CYC;
  localparam int FP_LIMIT = `FAST_PARK_CYC;
  localparam int CW = 20;

  // Last counter value of a phase whose wanted length is cut to a limit.
  function automatic logic [CW-1:0] last_count(input int want, input int limit);
    int n;
    n = (want < limit) ? want : limit;
    return CW'(n - 1);
  endfunction : last_count

  localparam logic [CW-1:0] PLL_N = last_count(PLL_LOCK_CYC, PLL_LOCK_CYC);
  localparam logic [CW-1:0] LOAD_N = last_count(CFG_LOAD_CYC, CFG_LOAD_CYC);
  localparam logic [CW-1:0] NP_N = last_count(NORMAL_PARK_CYC, NP_LIMIT);
  localparam logic [CW-1:0] FP_N = last_count(FAST_PARK_CYC, FP_LIMIT);

  wire nrst = link.system_reset_n & link.core_supply;
  logic [1:0] on_sync_reg;
  logic [1:0] fp_sync_reg;
  dev_state_t state_reg;
  dev_state_t state_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic fast_reg;
  logic fast_next;
  logic busy_reg;
  logic busy_next;
  logic drive_reg;

  // Asynchronous requests pass two flops before any logic sees them.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      on_sync_reg <= 2'h0;
      fp_sync_reg <= 2'h3;
    end
    else
    begin
      on_sync_reg <= {on_sync_reg[0], link.projector_on_request};
      fp_sync_reg <= {fp_sync_reg[0], link.fast_park_request_n};
    end
  end

  wire on_req = on_sync_reg[1];
  // A fault outranks the on request, so a fast park wins when both fall together.
  wire fast_req = ~fp_sync_reg[1];
  wire fast_pending = fast_req && !fast_reg;
  wire in_park = (state_reg == ST_PARK);
  wire pll_done = (state_reg == ST_PLL) && (cnt_reg == PLL_N);
  wire load_done = (state_reg == ST_LOAD) && (cnt_reg == LOAD_N);
  wire park_done = in_park && (cnt_reg == (fast_reg ? FP_N : NP_N));
  wire cnt_done = pll_done || load_done || park_done;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_done ? '0 : cnt_reg + 1'b1;
    fast_next = fast_reg;
    busy_next = busy_reg;
    case (state_reg)
      ST_RESET:
      begin
        state_next = ST_PLL;
        cnt_next = '0;
      end
      ST_PLL:
        if (cnt_done)
          state_next = ST_LOAD;
      ST_LOAD:
        if (cnt_done)
        begin
          // A request dropped during initialization is only acted on once loading ends.
          state_next = on_req ? ST_ON : ST_OFF;
          busy_next = 1'b0;
        end
      ST_ON:
      begin
        cnt_next = '0;
        if (fast_req)
        begin
          state_next = ST_PARK;
          fast_next = 1'b1;
        end
        else if (!on_req)
        begin
          state_next = ST_PARK;
          fast_next = 1'b0;
        end
      end
      ST_PARK:
      begin
        // A fault during a normal park switches to the shorter fast park.
        if (fast_pending)
        begin
          fast_next = 1'b1;
          cnt_next = '0;
        end
        else if (cnt_done)
          state_next = ST_OFF;
      end
      ST_OFF:
      begin
        cnt_next = '0;
        // Restart waits until the fault flag has cleared.
        if (on_req && !fast_req)
          state_next = ST_ON;
      end
      default:
        state_next = ST_RESET;
    endcase
  end

  // Decodes of the next state, so each output flop lines up with the state it belongs to.
  wire next_on = (state_next == ST_ON);
  wire next_active = next_on || (state_next == ST_PARK);
  wire park_end = (state_next == ST_OFF) && in_park;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= ST_RESET;
      cnt_reg <= '0;
      fast_reg <= 1'b0;
      busy_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      fast_reg <= fast_next;
      busy_reg <= busy_next;
    end
  end

  // The busy line is first driven one edge after release; until then the pull-up holds it high.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      drive_reg <= 1'b0;
    else
      drive_reg <= 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      projecting <= 1'b0;
      mirror_array_reset_n <= 1'b0;
      light_select_0 <= 1'b0;
      parked <= 1'b0;
      fast_parked <= 1'b0;
    end
    else
    begin
      projecting <= next_on;
      mirror_array_reset_n <= next_active;
      light_select_0 <= next_on;
      parked <= park_end;
      fast_parked <= park_end && fast_next;
    end
  end

  // In reset the strobes and mirror reset are held low by the flops above.
  assign outputs_oe_n = ~nrst | ~link.host_io_supply;
  assign link.init_busy_out = busy_reg;
  // Released in reset or without core power so the pull-up wins.
  assign link.init_busy_oe_n = ~(drive_reg & nrst);
endmodule : park_device
`default_nettype wire

// ===== park_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "park_seq_defs.svh"
module park_host #(
  parameter int RESET_HOLD_CYC = `RESET_HOLD_CYC,
  parameter int NORMAL_PARK_CYC = `NORMAL_PARK_CYC,
  parameter int FAST_PARK_CYC = `FAST_PARK_CYC,
  parameter int SUPPLY_HOLD_CYC = `SUPPLY_HOLD_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic power_on_cmd,
  input wire logic fault,
  park_link_if.host link,
  output logic ready
);
  import park_seq_pkg::*;

  localparam int CW = 24;
  localparam logic [CW-1:0] RH_N = CW'(RESET_HOLD_CYC - 1);
  localparam logic [CW-1:0] NP_N = CW'(NORMAL_PARK_CYC - 1);
  localparam logic [CW-1:0] FP_N = CW'(FAST_PARK_CYC - 1);
  localparam logic [CW-1:0] SH_N = CW'(SUPPLY_HOLD_CYC - 1);

  host_state_t state_reg;
  host_state_t state_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [1:0] busy_sync_reg;
  logic [1:0] fault_sync_reg;
  logic fast_reg;
  logic on_reg;
  logic rst_reg;
  logic park_reg;
  logic supply_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_sync_reg <= 2'h3;
      fault_sync_reg <= 2'h0;
    end
    else
    begin
      busy_sync_reg <= {busy_sync_reg[0], link.init_busy_line};
      fault_sync_reg <= {fault_sync_reg[0], fault};
    end
  end

  wire busy = busy_sync_reg[1];
  wire flt = fault_sync_reg[1];
  // A normal park holds for the longer of the park window and the supply hold.
  localparam logic [CW-1:0] HOLD_N = (SH_N > NP_N) ? SH_N : NP_N;
  wire [CW-1:0] park_lim = fast_reg ? FP_N : HOLD_N;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg + 1'b1;
    case (state_reg)
      HS_HOLD:
        // Reset stays low for the full hold time after supplies come up.
        if (!supply_reg || cnt_reg == RH_N || !power_on_cmd)
        begin
          cnt_next = '0;
          if (supply_reg && cnt_reg == RH_N)
            state_next = HS_WAIT_INIT;
        end
      HS_WAIT_INIT:
        if (!busy)
          state_next = HS_RUN;
      HS_RUN:
      begin
        cnt_next = '0;
        if (flt || !power_on_cmd)
          state_next = HS_PARK_WAIT;
      end
      HS_PARK_WAIT:
        if (cnt_reg == park_lim)
        begin
          state_next = HS_DONE;
          cnt_next = '0;
        end
      HS_DONE:
      begin
        cnt_next = '0;
        if (power_on_cmd && !flt)
          state_next = HS_HOLD;
      end
      default:
        state_next = HS_HOLD;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= HS_HOLD;
      cnt_reg <= '0;
      fast_reg <= 1'b0;
      on_reg <= 1'b0;
      rst_reg <= 1'b0;
      park_reg <= 1'b1;
      supply_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (state_reg == HS_RUN)
        fast_reg <= flt;
      on_reg <= (state_next == HS_WAIT_INIT) || (state_next == HS_RUN);
      rst_reg <= (state_next == HS_WAIT_INIT) || (state_next == HS_RUN) || (state_next == HS_PARK_WAIT);
      park_reg <= !((state_next == HS_PARK_WAIT) && flt) && state_next != HS_DONE;
      // Supplies follow the command only before reset release; afterwards they stay until the park window ends.
      supply_reg <= (state_next == HS_HOLD) ? power_on_cmd : (state_next != HS_DONE);
    end
  end

  assign link.projector_on_request = on_reg;
  assign link.system_reset_n = rst_reg;
  assign link.fast_park_request_n = park_reg;
  assign link.i2c_allowed = (state_reg == HS_RUN) && power_on_cmd && !flt;
  assign link.main_system_supply = supply_reg;
  assign link.host_io_supply = supply_reg;
  assign link.core_supply = supply_reg;
  assign ready = (state_reg == HS_RUN);
endmodule : park_host
`default_nettype wire

// ===== power_up_park_sequencer_props.sv
`timescale 1ns/1ps
`default_nettype none
module power_up_park_sequencer_props #(
  parameter int PLL_LOCK_CYC = 8,
  parameter int CFG_LOAD_CYC = 16,
  parameter int SUPPLY_HOLD_CYC = 200,
  parameter int FAST_PARK_CYC = 20,
  parameter int RESET_HOLD_CYC = 20
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic projector_on_request,
  input wire logic system_reset_n,
  input wire logic fast_park_request_n,
  input wire logic init_busy_out,
  input wire logic init_busy_oe_n,
  input wire logic init_busy_line,
  input wire logic i2c_allowed,
  input wire logic main_system_supply,
  input wire logic core_supply
);
  localparam int INIT_LO = PLL_LOCK_CYC + CFG_LOAD_CYC - 1;
  localparam int INIT_HI = INIT_LO + 3;
  localparam int SUP_D = SUPPLY_HOLD_CYC - 1;
  localparam int FAST_D = FAST_PARK_CYC - 1;
  logic [31:0] low_cnt_reg;
  // Counts reset-low cycles with the core up; one cycle of slack covers the register delay.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      low_cnt_reg <= 32'h0000_0000;
    else if (system_reset_n || !core_supply)
      low_cnt_reg <= 32'h0000_0000;
    else
      low_cnt_reg <= low_cnt_reg + 32'h0000_0001;
  end
  default clocking cb @(posedge clk);
  endclocking
  sequence release_s;
    $rose(system_reset_n) && core_supply;
  endsequence
  a_busy_released: assert property (disable iff (!nrst) !system_reset_n |-> init_busy_oe_n && init_busy_line)
    else $error("init busy driven in reset");
  a_busy_driven: assert property (disable iff (!system_reset_n) release_s |=> !init_busy_oe_n && init_busy_out)
    else $error("init busy not driven high");
  a_busy_held: assert property (disable iff (!system_reset_n) release_s |-> init_busy_line [*8])
    else $error("init busy dropped early");
  a_init_done: assert property (disable iff (!system_reset_n) release_s |-> ##[INIT_LO:INIT_HI] !init_busy_line)
    else $error("init done late");
  a_park_high_first: assert property (disable iff (!nrst) $rose(system_reset_n) |-> fast_park_request_n)
    else $error("reset released with fast park low");
  a_reset_hold: assert property (disable iff (!nrst) $rose(system_reset_n) |-> low_cnt_reg >= RESET_HOLD_CYC - 1)
    else $error("reset released too soon");
  a_i2c_gated: assert property (disable iff (!nrst) i2c_allowed |-> system_reset_n && !init_busy_line)
    else $error("bus traffic during init");
  a_i2c_stopped: assert property (disable iff (!nrst) $fell(projector_on_request) |-> !i2c_allowed)
    else $error("bus traffic at power down");
  a_on_after_init: assert property (disable iff (!nrst) $fell(projector_on_request) && system_reset_n |-> !init_busy_line)
    else $error("on request dropped during init");
  a_normal_hold: assert property (disable iff (!nrst)
    $fell(projector_on_request) && fast_park_request_n |-> ##SUP_D system_reset_n && main_system_supply)
    else $error("supply cut early in normal park");
  a_fast_hold: assert property (disable iff (!nrst) $fell(fast_park_request_n) |-> ##FAST_D system_reset_n && core_supply)
    else $error("supply cut early in fast park");
endmodule : power_up_park_sequencer_props
`default_nettype wire

// ===== power_up_park_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module power_up_park_sequencer_tb_top;
  import park_seq_pkg::*;
  localparam int NP = 40;
  localparam int FP = 10;
  localparam int PLL = 8;
  localparam int CFG = 16;
  localparam int RH = 20;
  localparam int HNP = 100;
  localparam int HFP = 20;
  localparam int SH = 200;
  logic clk, nrst, power_on_cmd, fault, ready, projecting, mirror_array_reset_n;
  logic light_select_0, parked, fast_parked, outputs_oe_n, fast;
  int n_mismatch, checks_done, seed, n;
  park_link_if link ();
  park_host #(.RESET_HOLD_CYC(RH), .NORMAL_PARK_CYC(HNP), .FAST_PARK_CYC(HFP), .SUPPLY_HOLD_CYC(SH)) i_park_host (
    .clk(clk), .nrst(nrst), .power_on_cmd(power_on_cmd), .fault(fault), .link(link), .ready(ready));
  park_device #(.PLL_LOCK_CYC(PLL), .CFG_LOAD_CYC(CFG), .NORMAL_PARK_CYC(NP), .FAST_PARK_CYC(FP)) i_park_device (
    .clk(clk), .link(link), .projecting(projecting), .mirror_array_reset_n(mirror_array_reset_n),
    .light_select_0(light_select_0), .parked(parked), .fast_parked(fast_parked), .outputs_oe_n(outputs_oe_n));
  power_up_park_sequencer_props #(.PLL_LOCK_CYC(PLL), .CFG_LOAD_CYC(CFG), .SUPPLY_HOLD_CYC(SH),
    .FAST_PARK_CYC(HFP), .RESET_HOLD_CYC(RH)) i_props (.clk(clk), .nrst(nrst),
    .projector_on_request(link.projector_on_request),
    .system_reset_n(link.system_reset_n), .fast_park_request_n(link.fast_park_request_n),
    .init_busy_out(link.init_busy_out), .init_busy_oe_n(link.init_busy_oe_n), .init_busy_line(link.init_busy_line),
    .i2c_allowed(link.i2c_allowed), .main_system_supply(link.main_system_supply), .core_supply(link.core_supply));
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  // Waits off the edge for ready, a park pulse or reset, bounded so a hang ends the run.
  task wait_on(input int which, output int cyc);
    logic hit;
    cyc = 0;
    hit = 1'b0;
    while (!hit)
    begin
      @(posedge clk);
      #1;
      cyc++;
      hit = (which == 0) ? (ready === 1'b1) : (which == 1) ? (parked === 1'b1) : (link.system_reset_n === 1'b0);
      if (cyc > 2000)
      begin
        n_mismatch++;
        stop_test();
      end
    end
  endtask : wait_on
  function logic park_in_time(input logic f, input int cyc);
    return cyc <= ((f ? FP : NP) + 6);
  endfunction : park_in_time
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    seed = 32'hbb81;
    nrst = 1'b0;
    power_on_cmd = 1'b0;
    fault = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      fast = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : 1'($random(seed));
      @(posedge clk);
      power_on_cmd <= 1'b1;
      wait_on(0, n);
      check("busy_line", link.init_busy_line, 1'b0);
      repeat (4) @(posedge clk);
      #1;
      check("projecting", projecting, 1'b1);
      repeat ((i == 0) ? 0 : ($random(seed) & 15)) @(posedge clk);
      @(posedge clk);
      power_on_cmd <= fast;
      fault <= fast;
      wait_on(1, n);
      check("park_time", park_in_time(fast, n), 1'b1);
      check("fast_parked", fast_parked, fast);
      check("projecting", projecting, 1'b0);
      wait_on(2, n);
      check("busy_line", link.init_busy_line, 1'b1);
      check("mirror_rst_n", mirror_array_reset_n, 1'b0);
      check("light_sel", light_select_0, 1'b0);
      check("outputs_oe_n", outputs_oe_n, 1'b1);
      @(posedge clk);
      fault <= 1'b0;
      power_on_cmd <= 1'b0;
      nrst <= 1'b0;
      @(posedge clk);
      nrst <= 1'b1;
    end
    stop_test();
  end
endmodule : power_up_park_sequencer_tb_top
`default_nettype wire
